// [design/amc_clock_divider.sv]
// Purpose: Converter clock divider, system clock divided by divider value plus one.
// Assumes: Divider value is held stable by the caller between restarts.
// Notes:   A divider value of zero gives a tick every cycle and a steady high clock.
`timescale 1ns/10ps
module amc_clock_divider #(
  parameter int DIV_W = 5
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             restart_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  tick_o,
  output logic                  conv_clk_o
);
  logic [DIV_W-1:0] count; // Position within one converter clock period.

  // Count from zero to the divider value, so one period is div_i + 1 cycles.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= '0;
    end else if (restart_i || (count == div_i)) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // Tick marks the last cycle of each period, so it is combinational on the count.
  assign tick_o = (count == div_i) && !restart_i;

  // Clock output is high for the first half of the period; registered to stay glitch free.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_clk_o <= 1'b0;
    end else begin
      conv_clk_o <= restart_i || (count < (div_i >> 1)) || (count == div_i);
    end
  end
endmodule // amc_clock_divider

// [design/amc_mux_gain_clock.sv]
// Purpose: Configuration and sequencing of the converter input mux, amplifier gain and clock.
// Assumes: Converter core and start source share CLK_I; enable and tracking bits come in as pins.
// Notes:   Settings are captured at each conversion start and held until it ends.
`timescale 1ns/10ps
module amc_mux_gain_clock #(
  parameter int RES_W = 10,
  parameter int DIV_W = 5
) (
  input  wire logic             CLK_I,
  input  wire logic             ARST_N_I,
  input  wire logic [7:0]       SFR_ADDR_I,
  input  wire logic [7:0]       SFR_WDATA_I,
  input  wire logic             SFR_WR_I,
  input  wire logic             SFR_RD_I,
  output logic      [7:0]       SFR_RDATA_O,
  input  wire logic             CONVERTER_ENABLE_I,
  input  wire logic             LOW_POWER_TRACK_SEL_I,
  input  wire logic             CONV_START_I,
  input  wire logic [RES_W-1:0] SAR_RESULT_I,
  output logic      [3:0]       POS_SEL_O,
  output logic      [2:0]       NEG_SEL_O,
  output logic                  DIFF_O,
  output logic      [2:0]       GAIN_CODE_O,
  output logic                  CONVERTER_CLOCK_O,
  output logic                  SHUTDOWN_O,
  output logic                  TRACK_O,
  output logic                  SAR_STEP_O,
  output logic                  BUSY_O,
  output logic                  DONE_O,
  output logic      [RES_W-1:0] DATA_O
);
  logic [7:0]             input_pair_config;           // Pair mode bits.
  logic [7:0]             input_channel_select;        // Channel code.
  logic [7:0]             converter_clock_gain_config; // Divider and gain.
  amc_pkg::amc_state_e    state;                       // Sequencer state.
  logic [4:0]             tick_count;                  // Converter clocks in this phase.
  logic [DIV_W-1:0]       held_div;                    // Divider used by the running clock.
  logic                   tick;                        // Last cycle of a converter clock.
  logic                   start_ok;                    // Accepted conversion start.
  logic [3:0]             next_pos;                    // Decoded positive leg.
  logic [2:0]             next_neg;                    // Decoded negative leg.
  logic                   next_diff;                   // Decoded pair mode.
  logic [2:0]             next_gain;                   // Normalised gain code.
  logic [2:0]             chan_num;                    // Input number part of the code.
  logic [1:0]             pair_num;                    // Pair holding that input.

  // Register writes; the mux registers keep only their low nibble.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      input_pair_config           <= amc_pkg::RST_INPUT_PAIR_CONFIG;
      input_channel_select        <= amc_pkg::RST_INPUT_CHANNEL_SELECT;
      converter_clock_gain_config <= amc_pkg::RST_CONV_CLOCK_GAIN_CFG;
    end else if (SFR_WR_I) begin
      case (SFR_ADDR_I)
        amc_pkg::ADDR_INPUT_PAIR_CONFIG: begin
          input_pair_config <= SFR_WDATA_I & amc_pkg::MUX_REG_MASK;
        end
        amc_pkg::ADDR_INPUT_CHANNEL_SELECT: begin
          input_channel_select <= SFR_WDATA_I & amc_pkg::MUX_REG_MASK;
        end
        amc_pkg::ADDR_CONV_CLOCK_GAIN_CFG: begin
          converter_clock_gain_config <= SFR_WDATA_I;
        end
        default: begin
          // Other addresses belong to other peripherals and are ignored here.
        end
      endcase
    end
  end

  // Read data is registered one cycle after the read strobe; other addresses read zero.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SFR_RDATA_O <= 8'h00;
    end else if (SFR_RD_I) begin
      case (SFR_ADDR_I)
        amc_pkg::ADDR_INPUT_PAIR_CONFIG: begin
          SFR_RDATA_O <= input_pair_config & amc_pkg::MUX_REG_MASK;
        end
        amc_pkg::ADDR_INPUT_CHANNEL_SELECT: begin
          SFR_RDATA_O <= input_channel_select & amc_pkg::MUX_REG_MASK;
        end
        amc_pkg::ADDR_CONV_CLOCK_GAIN_CFG: begin
          SFR_RDATA_O <= converter_clock_gain_config;
        end
        default: begin
          SFR_RDATA_O <= 8'h00;
        end
      endcase
    end
  end

  // Decode the channel code against the pair bits; the result is only taken at a start.
  always_comb begin
    chan_num  = input_channel_select[2:0];
    pair_num  = chan_num[2:1];
    next_pos  = {1'b0, chan_num};
    next_neg  = chan_num;
    next_diff = 1'b0;
    if (input_channel_select[amc_pkg::CHAN_TEMP_BIT]) begin
      next_pos = amc_pkg::SEL_TEMP_SENSOR;
    end else if (input_pair_config[pair_num]) begin
      // Either member of an enabled pair converts the pair, even leg positive.
      next_pos  = {1'b0, pair_num, 1'b0};
      next_neg  = {pair_num, 1'b1};
      next_diff = 1'b1;
    end
  end

  // Gain codes 10x and 11x ignore their low bit, so it is cleared for the amplifier.
  always_comb begin
    next_gain = converter_clock_gain_config[amc_pkg::GAIN_MSB:0];
    if (next_gain[2]) begin
      next_gain[0] = 1'b0;
    end
  end

  // A start is honoured only while enabled and idle; a start during a conversion is dropped.
  assign start_ok = CONV_START_I && CONVERTER_ENABLE_I && (state == amc_pkg::ST_IDLE);

  // Snapshot of the datapath settings, taken only when a conversion begins.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      POS_SEL_O   <= 4'h0;
      NEG_SEL_O   <= 3'h0;
      DIFF_O      <= 1'b0;
      GAIN_CODE_O <= 3'h0;
      held_div    <= amc_pkg::RST_CONV_CLOCK_GAIN_CFG[amc_pkg::DIV_MSB:amc_pkg::DIV_LSB];
    end else if (start_ok) begin
      POS_SEL_O   <= next_pos;
      NEG_SEL_O   <= next_neg;
      DIFF_O      <= next_diff;
      GAIN_CODE_O <= next_gain;
      held_div    <= converter_clock_gain_config[amc_pkg::DIV_MSB:amc_pkg::DIV_LSB];
    end
  end

  // The divider restarts on each accepted start so phases line up with whole periods.
  amc_clock_divider #(
    .DIV_W (DIV_W)
  ) u_divider (
    .clk_i      (CLK_I),
    .arst_n_i   (ARST_N_I),
    .restart_i  (start_ok),
    .div_i      (held_div),
    .tick_o     (tick),
    .conv_clk_o (CONVERTER_CLOCK_O)
  );

  // Sequencer: optional tracking phase, then the successive-approximation steps.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state      <= amc_pkg::ST_IDLE;
      tick_count <= 5'h00;
    end else if (!CONVERTER_ENABLE_I) begin
      state      <= amc_pkg::ST_IDLE;
      tick_count <= 5'h00;
    end else begin
      case (state)
        amc_pkg::ST_IDLE: begin
          tick_count <= 5'h00;
          if (start_ok) begin
            state <= LOW_POWER_TRACK_SEL_I ? amc_pkg::ST_TRACK : amc_pkg::ST_CONVERT;
          end
        end
        amc_pkg::ST_TRACK: begin
          if (tick) begin
            if (tick_count == amc_pkg::TRACK_TICKS - 5'h01) begin
              state      <= amc_pkg::ST_CONVERT;
              tick_count <= 5'h00;
            end else begin
              tick_count <= tick_count + 5'h01;
            end
          end
        end
        amc_pkg::ST_CONVERT: begin
          if (tick) begin
            if (tick_count == amc_pkg::CONV_TICKS - 5'h01) begin
              state      <= amc_pkg::ST_IDLE;
              tick_count <= 5'h00;
            end else begin
              tick_count <= tick_count + 5'h01;
            end
          end
        end
        default: begin
          state      <= amc_pkg::ST_IDLE;
          tick_count <= 5'h00;
        end
      endcase
    end
  end

  // Result capture on the last step; the core's offset-binary differential result has its
  // top bit inverted, which is exactly the two's-complement form.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DATA_O <= '0;
      DONE_O <= 1'b0;
    end else begin
      DONE_O <= 1'b0;
      if (CONVERTER_ENABLE_I && (state == amc_pkg::ST_CONVERT) && tick &&
          (tick_count == amc_pkg::CONV_TICKS - 5'h01)) begin
        DONE_O <= 1'b1;
        if (DIFF_O) begin
          DATA_O <= {~SAR_RESULT_I[RES_W-1], SAR_RESULT_I[RES_W-2:0]};
        end else begin
          DATA_O <= SAR_RESULT_I;
        end
      end
    end
  end

  // Status decoded from the state and enable; continuous tracking whenever enabled, idle and not low-power.
  assign SHUTDOWN_O = !CONVERTER_ENABLE_I;
  assign BUSY_O     = (state != amc_pkg::ST_IDLE);
  assign SAR_STEP_O = (state == amc_pkg::ST_CONVERT);
  assign TRACK_O    = CONVERTER_ENABLE_I &&
                      ((state == amc_pkg::ST_TRACK) ||
                       ((state == amc_pkg::ST_IDLE) && !LOW_POWER_TRACK_SEL_I));
endmodule // amc_mux_gain_clock

// [design/amc_pkg.sv]
// Purpose: Shared constants for the converter mux, gain and clock configuration block.
// Assumes: 8-bit special function register bus, one system clock.
// Notes:   Offsets are the special function register addresses of the three registers.
package amc_pkg;
  // Register addresses.
  localparam logic [7:0] ADDR_INPUT_PAIR_CONFIG    = 8'hba;
  localparam logic [7:0] ADDR_INPUT_CHANNEL_SELECT = 8'hbb;
  localparam logic [7:0] ADDR_CONV_CLOCK_GAIN_CFG  = 8'hbc;
  // Reset values.
  localparam logic [7:0] RST_INPUT_PAIR_CONFIG    = 8'h00;
  localparam logic [7:0] RST_INPUT_CHANNEL_SELECT = 8'h00;
  localparam logic [7:0] RST_CONV_CLOCK_GAIN_CFG  = 8'hf8;
  // Writable bits of the two mux registers; the upper nibble is unused.
  localparam logic [7:0] MUX_REG_MASK = 8'h0f;
  // Field positions in the clock and gain register.
  localparam int DIV_LSB  = 3;
  localparam int DIV_MSB  = 7;
  localparam int GAIN_MSB = 2;
  // Channel code layout: top bit picks the temperature sensor.
  localparam int CHAN_TEMP_BIT = 3;
  // Selection code driven for the temperature sensor channel.
  localparam logic [3:0] SEL_TEMP_SENSOR = 4'h8;
  // Sequencing counts in converter-clock periods.
  localparam logic [4:0] TRACK_TICKS = 5'h03;
  localparam logic [4:0] CONV_TICKS  = 5'h10;
  // Conversion sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_TRACK   = 3'b010,
    ST_CONVERT = 3'b100
  } amc_state_e;
endpackage

// [sim/amc_core_model.sv]
// Purpose: Converter core stand-in that returns a result coded from the selects.
// Assumes: The result is only meaningful while the steps run.
// Notes:   Outside the steps the result churns, so a stale sample shows up.
`timescale 1ns/10ps
module amc_core_model (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       step_i,
  input  wire logic       diff_i,
  input  wire logic [3:0] pos_i,
  input  wire logic [2:0] neg_i,
  input  wire logic [2:0] gain_i,
  output logic      [9:0] result_o
);
  logic [9:0] churn; // Changes every cycle.
  // Free-running pattern rather than a held value, like an undriven bus.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) churn <= 10'h2a5;
    else churn <= churn + 10'h15b;
  end
  // The negative leg only matters for a differential pair.
  assign result_o = step_i ? {pos_i, diff_i ? neg_i : 3'h5, gain_i} : churn;
endmodule // amc_core_model

// [sim/amc_props.sv]
// Purpose: Port properties of the converter mux, gain and clock block.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to the top module by the testbench.
`timescale 1ns/10ps
module amc_props #(parameter int RES_W = 10) (
  input wire logic             CLK_I,
  input wire logic             ARST_N_I,
  input wire logic             CONVERTER_ENABLE_I,
  input wire logic             LOW_POWER_TRACK_SEL_I,
  input wire logic             CONV_START_I,
  input wire logic [RES_W-1:0] SAR_RESULT_I,
  input wire logic [3:0]       POS_SEL_O,
  input wire logic [2:0]       NEG_SEL_O,
  input wire logic             DIFF_O,
  input wire logic [2:0]       GAIN_CODE_O,
  input wire logic             TRACK_O,
  input wire logic             SHUTDOWN_O,
  input wire logic             SAR_STEP_O,
  input wire logic             BUSY_O,
  input wire logic             DONE_O,
  input wire logic [RES_W-1:0] DATA_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // A start counts only when idle and enabled; any other is dropped.
  sequence s_start; !BUSY_O && CONV_START_I && CONVERTER_ENABLE_I; endsequence
  sequence s_track3; (TRACK_O && !SAR_STEP_O)[*3]; endsequence
  property p_lp_track; s_start ##0 LOW_POWER_TRACK_SEL_I |=> s_track3; endproperty
  a_lp_track: assert property (p_lp_track) else $error("tracking phase too short");
  property p_cont; !BUSY_O && CONVERTER_ENABLE_I && !LOW_POWER_TRACK_SEL_I |-> TRACK_O; endproperty
  a_cont: assert property (p_cont) else $error("idle input not tracked");
  property p_pair; DIFF_O |-> !POS_SEL_O[0] && NEG_SEL_O == POS_SEL_O[2:0] + 3'h1; endproperty
  a_pair: assert property (p_pair) else $error("pair legs wrong");
  property p_temp; POS_SEL_O[3] |-> POS_SEL_O == 4'h8 && !DIFF_O; endproperty
  a_temp: assert property (p_temp) else $error("sensor select wrong");
  property p_gain; GAIN_CODE_O[2] |-> !GAIN_CODE_O[0]; endproperty
  a_gain: assert property (p_gain) else $error("gain low bit not ignored");
  property p_abort; !CONVERTER_ENABLE_I |=> !BUSY_O; endproperty
  a_abort: assert property (p_abort) else $error("busy while disabled");
  property p_shut; !CONVERTER_ENABLE_I |-> SHUTDOWN_O && !TRACK_O; endproperty
  a_shut: assert property (p_shut) else $error("not shut down while disabled");
  property p_hold; BUSY_O && $past(BUSY_O) |-> $stable(POS_SEL_O) && $stable(GAIN_CODE_O); endproperty
  a_hold: assert property (p_hold) else $error("selects moved mid conversion");
  property p_data;
    DONE_O |-> DATA_O == ($past(SAR_RESULT_I) ^ {DIFF_O, {(RES_W-1){1'b0}}});
  endproperty
  a_data: assert property (p_data) else $error("result format wrong");
endmodule // amc_props

// [sim/test_adc_mux_gain_clock.sv]
// Purpose: Self-checking bench for the converter mux, gain and clock block.
// Assumes: 125 MHz clock; the core model answers during the steps.
// Notes:   Expected values come from integer models of the select rules.
`timescale 1ns/10ps
module test_adc_mux_gain_clock;
  logic       clk, arst_n, wr, rd, en, lp, start, diff, step, busy, done, cclk, sd;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] pos;
  logic [2:0] neg, gain;
  logic [9:0] raw, data;
  int         error_cnt, cmp_count, cfg, ch, g, dv, k;
  // Register walk: three mapped addresses, then an unmapped one.
  logic [7:0] ra [4] = '{8'hba, 8'hbb, 8'hbc, 8'hc0};
  logic [7:0] rv [4] = '{8'h00, 8'h00, 8'hf8, 8'h00};
  logic [7:0] fv [4] = '{8'h0f, 8'h0f, 8'hff, 8'h00};
  amc_mux_gain_clock u_amc_mux_gain_clock (.CLK_I(clk), .ARST_N_I(arst_n), .SFR_ADDR_I(addr),
    .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_RDATA_O(rdata),
    .CONVERTER_ENABLE_I(en), .LOW_POWER_TRACK_SEL_I(lp), .CONV_START_I(start),
    .SAR_RESULT_I(raw), .POS_SEL_O(pos), .NEG_SEL_O(neg), .DIFF_O(diff), .GAIN_CODE_O(gain),
    .CONVERTER_CLOCK_O(cclk), .SHUTDOWN_O(sd), .TRACK_O(), .SAR_STEP_O(step), .BUSY_O(busy),
    .DONE_O(done), .DATA_O(data));
  amc_core_model u_amc_core_model (.clk_i(clk), .arst_n_i(arst_n), .step_i(step),
    .diff_i(diff), .pos_i(pos), .neg_i(neg), .gain_i(gain), .result_o(raw));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input int exp, input logic [9:0] got);
    cmp_count++;
    if (got !== 10'(exp)) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, 10'(exp), got);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One register cycle; read data is settled just after the second edge.
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, rd} <= {w, !w};
    addr <= a;
    wdata <= d;
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1;
  endtask
  // One conversion; ab above zero drops enable at that cycle instead.
  task automatic conv(input int ab);
    int n, df, p, gg, rises, prev;
    df = (ch < 8) && cfg[ch/2];
    p = ch >= 8 ? 8 : (df ? ch & 6 : ch);
    gg = g >= 4 ? g & 6 : g;
    n = 0;
    rises = 0;
    prev = 1; // The restart forces the converter clock high at the start edge.
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      wr <= n == 2; // A write mid-conversion must not reach the selects.
      addr <= 8'hbb;
      wdata <= 8'(ch ^ 5);
      if (n == ab) en <= 1'b0;
      #1;
      if (cclk && !prev) rises++; // One rising edge per converter clock period.
      prev = cclk;
    end while (!done && n < 400);
    if (ab > 0) begin
      chk("abort", 400, 10'(n));
      chk("shutdown", 1, 10'(sd));
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      en <= 1'b1;
      #1 chk("ignored", 0, 10'(busy));
    end else begin
      if (n >= 400) begin
        error_cnt++;
        wrap_up();
      end
      chk("latency", ((lp ? 3 : 0) + 16) * (dv + 1), 10'(n));
      if (dv > 0) chk("clock", (lp ? 3 : 0) + 16, 10'(rises));
      chk("pos", p, 10'(pos));
      chk("diff", df, 10'(diff));
      if (df) chk("neg", p + 1, 10'(neg));
      chk("gain", gg, 10'(gain));
      chk("data", (p * 64 + (df ? p + 1 : 5) * 8 + gg) ^ (df * 512), data);
    end
  endtask
  initial begin
    {wr, rd, lp, start, arst_n} = 5'h00;
    en = 1'b1;
    {addr, wdata} = 16'h0000;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(2));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (k = 0; k < 4; k++) begin
      sfr(1'b0, ra[k], 8'h00);
      chk("reset", rv[k], 10'(rdata));
      sfr(1'b1, ra[k], 8'hff);
      sfr(1'b0, ra[k], 8'h00);
      chk("mask", fv[k], 10'(rdata));
    end
    // Every channel and gain code, with random pairs, dividers and modes.
    for (k = 0; k < 32; k++) begin
      cfg = $urandom % 256;
      ch = k % 16;
      g = k % 8;
      dv = $urandom % 4;
      sfr(1'b1, 8'hba, 8'(cfg));
      sfr(1'b1, 8'hbb, 8'(ch + 16 * k));
      sfr(1'b1, 8'hbc, 8'(dv * 8 + g));
      cfg = cfg & 15;
      @(posedge clk);
      lp <= 1'($urandom % 2);
      repeat (3) @(posedge clk);
      conv(0);
    end
    @(posedge clk);
    lp <= 1'b0;
    conv(5);
    wrap_up();
  end
endmodule // test_adc_mux_gain_clock
bind amc_mux_gain_clock amc_props #(.RES_W(RES_W)) u_amc_props (.CLK_I, .ARST_N_I,
  .CONVERTER_ENABLE_I, .LOW_POWER_TRACK_SEL_I, .CONV_START_I, .SAR_RESULT_I, .POS_SEL_O,
  .NEG_SEL_O, .DIFF_O, .GAIN_CODE_O, .TRACK_O, .SHUTDOWN_O, .SAR_STEP_O, .BUSY_O, .DONE_O,
  .DATA_O);
